// [hdl/apf_core.sv]
// active power to frequency signal path with apb status registers
//
// Chosen here: the APB interface to the registers and the register offsets.
module apf_core
    import apf_pkg::*;
#(
    parameter int FIFO_DEPTH = 16,
    parameter int CAL_THRESH_LOG2 = 24,
    parameter int PULSE_CYC = APF_PULSE_CYC
)
(
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic analog_supply_ok_in,
    input wire logic gain_sel_lsb_in,
    input wire logic gain_sel_msb_in,
    input wire logic hpf_enable_pin_in,
    input wire logic freq_sel_lsb_in,
    input wire logic freq_sel_msb_in,
    input wire logic sample_valid_in,
    input wire apf_sample_t sample_in,
    output logic sample_ready_out,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output logic cal_pulse_out,
    output logic slow_pulse_a_n_out,
    output logic slow_pulse_b_n_out
);
    localparam int SFW = $clog2(APF_SUPPLY_FILT + 1);
    localparam int PW = $clog2(PULSE_CYC + 1);
    localparam logic [APF_PROD_W-1:0] CAL_THRESH = APF_PROD_W'(1) << CAL_THRESH_LOG2;

    // multiply current by the selected gain
    function automatic logic signed [23:0] apply_gain(input logic signed [15:0] x, input logic [1:0] sel);
        logic signed [23:0] w;
        w = 24'(x);
        case (sel)
            2'h0: apply_gain = w;
            2'h1: apply_gain = w <<< 1;
            2'h2: apply_gain = w <<< 3;
            default: apply_gain = w <<< 4;
        endcase
    endfunction

    // ----------------------------------------
    // pin synchronisers and supply monitor
    // ----------------------------------------
    apf_pins_t pin_meta;
    apf_pins_t pin_sync;
    apf_pins_t pin_raw;
    logic [SFW-1:0] sup_cnt;
    logic [SFW-1:0] next_sup_cnt;
    logic supply_good;
    logic next_supply_good;
    logic rst_int;
    logic soft_hold;
    logic [1:0] gain_sel;
    logic [1:0] freq_sel;
    logic hpf_on;

    assign pin_raw = '{gain_lsb: gain_sel_lsb_in, gain_msb: gain_sel_msb_in, hpf_en: hpf_enable_pin_in,
                       fsel_lsb: freq_sel_lsb_in, fsel_msb: freq_sel_msb_in, supply_ok: analog_supply_ok_in};
    assign gain_sel = {pin_sync.gain_msb, pin_sync.gain_lsb}; // [R1]
    assign freq_sel = {pin_sync.fsel_msb, pin_sync.fsel_lsb}; // [R12]
    assign hpf_on = pin_sync.hpf_en; // [R3]
    assign rst_int = srst_in || !supply_good || soft_hold; // [R2] [R13]

    // supply must stay good for a filter window before release
    always_comb
    begin
        next_sup_cnt = sup_cnt;
        next_supply_good = supply_good;
        if (!pin_sync.supply_ok)
        begin
            next_sup_cnt = '0; // [R2]
            next_supply_good = 1'b0;
        end
        else if (sup_cnt != SFW'(APF_SUPPLY_FILT))
            next_sup_cnt = sup_cnt + 1'b1;
        else
            next_supply_good = 1'b1;
    end

    // two-stage sync and monitor registers
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            pin_meta <= '0;
            pin_sync <= '0;
            sup_cnt <= '0;
            supply_good <= 1'b0;
        end
        else
        begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
            sup_cnt <= next_sup_cnt;
            supply_good <= next_supply_good;
        end
    end

    // ----------------------------------------
    // sample fifo and paced drain
    // ----------------------------------------
    apf_sample_t fifo_data;
    logic fifo_valid;
    logic drain_ready;
    logic [4:0] fifo_level;
    logic [2:0] pace;
    logic [2:0] next_pace;
    logic pop;

    apf_fifo #(.WIDTH($bits(apf_sample_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_in(clk_in),
        .srst_in(rst_int),
        .in_valid_in(sample_valid_in),
        .in_data_in(sample_in),
        .in_ready_out(sample_ready_out),
        .out_valid_out(fifo_valid),
        .out_data_out(fifo_data),
        .out_ready_in(drain_ready),
        .level_out(fifo_level)
    );

    assign drain_ready = (pace == '0);
    assign pop = fifo_valid && drain_ready;

    // ----------------------------------------
    // high-pass, phase compensation, multiply, low-pass
    // ----------------------------------------
    logic signed [23:0] gain_cur;
    logic signed [23:0] x_prev;
    logic signed [23:0] hpf_y;
    logic signed [23:0] cur_q;
    logic signed [15:0] volt_q;
    logic stage_vld;
    logic signed [APF_PROD_W-1:0] lpf_y;
    logic lpf_vld;
    logic signed [23:0] next_hpf_y;
    logic signed [23:0] next_cur;
    logic signed [APF_PROD_W-1:0] prod;
    logic signed [APF_PROD_W-1:0] next_lpf_y;

    // one sample per pop; compensation tracks the filter state
    always_comb
    begin
        next_pace = (pace != '0) ? pace - 1'b1 : (pop ? 3'(APF_SAMPLE_GAP - 1) : '0);
        gain_cur = apply_gain(fifo_data.cur, gain_sel); // [R1]
        next_hpf_y = hpf_on ? gain_cur - x_prev + hpf_y - (hpf_y >>> APF_HPF_SHIFT) : gain_cur; // [R3]
        next_cur = hpf_on ? next_hpf_y + ((next_hpf_y - hpf_y) >>> APF_PC_SHIFT) : gain_cur; // [R4]
        prod = APF_PROD_W'(cur_q) * APF_PROD_W'(volt_q); // [R5]
        next_lpf_y = lpf_y + ((prod - lpf_y) >>> APF_LPF_SHIFT); // [R6]
    end

    // filter state registers, cleared under any reset
    always_ff @(posedge clk_in)
    begin
        if (rst_int)
        begin
            pace <= '0;
            x_prev <= '0;
            hpf_y <= '0;
            cur_q <= '0;
            volt_q <= '0;
            stage_vld <= 1'b0;
            lpf_y <= '0;
            lpf_vld <= 1'b0;
        end
        else
        begin
            pace <= next_pace;
            stage_vld <= pop;
            lpf_vld <= stage_vld;
            if (pop)
            begin
                x_prev <= gain_cur;
                hpf_y <= next_hpf_y;
                cur_q <= next_cur;
                volt_q <= fifo_data.volt;
            end
            if (stage_vld)
                lpf_y <= next_lpf_y; // [R5] [R6]
        end
    end

    // ----------------------------------------
    // digital to frequency conversion
    // ----------------------------------------
    logic [APF_PROD_W-1:0] cal_acc;
    logic [APF_PROD_W-1:0] next_cal_acc;
    logic [11:0] ratio_cnt;
    logic [11:0] next_ratio_cnt;
    logic [11:0] ratio;
    logic cal_evt;
    logic slow_evt;
    logic slow_sel;
    logic next_slow_sel;
    logic [31:0] cal_count;
    logic [PW-1:0] cal_tmr;
    logic [PW-1:0] slow_tmr;
    logic [PW-1:0] next_cal_tmr;
    logic [PW-1:0] next_slow_tmr;

    // ratio halves for each step of the frequency select
    assign ratio = 12'(1 << (APF_MAX_RATIO_LOG2 - int'(freq_sel))); // [R8] [R12]

    always_comb
    begin
        next_cal_acc = cal_acc;
        if (lpf_vld && !lpf_y[APF_PROD_W-1])
            next_cal_acc = cal_acc + lpf_y; // [R7]
        cal_evt = (next_cal_acc >= CAL_THRESH);
        if (cal_evt)
            next_cal_acc = next_cal_acc - CAL_THRESH;
        next_ratio_cnt = ratio_cnt;
        slow_evt = 1'b0;
        if (cal_evt)
        begin
            if (ratio_cnt + 1'b1 >= ratio)
            begin
                next_ratio_cnt = '0; // [R9]
                slow_evt = 1'b1;
            end
            else
                next_ratio_cnt = ratio_cnt + 1'b1;
        end
        next_slow_sel = slow_evt ? !slow_sel : slow_sel;
        next_cal_tmr = cal_evt ? PW'(PULSE_CYC) : (cal_tmr != '0 ? cal_tmr - 1'b1 : '0);
        next_slow_tmr = slow_evt ? PW'(PULSE_CYC) : (slow_tmr != '0 ? slow_tmr - 1'b1 : '0);
    end

    // accumulators and pulse stretchers
    always_ff @(posedge clk_in)
    begin
        if (rst_int)
        begin
            cal_acc <= '0;
            ratio_cnt <= '0;
            slow_sel <= 1'b0;
            cal_count <= '0;
            cal_tmr <= '0;
            slow_tmr <= '0;
        end
        else
        begin
            cal_acc <= next_cal_acc;
            ratio_cnt <= next_ratio_cnt;
            slow_sel <= next_slow_sel;
            cal_count <= cal_evt ? cal_count + 1'b1 : cal_count;
            cal_tmr <= next_cal_tmr;
            slow_tmr <= next_slow_tmr;
        end
    end

    // registered pulse outputs, idle during reset
    always_ff @(posedge clk_in)
    begin
        if (rst_int)
        begin
            cal_pulse_out <= 1'b0; // [R13]
            slow_pulse_a_n_out <= 1'b1;
            slow_pulse_b_n_out <= 1'b1;
        end
        else
        begin
            cal_pulse_out <= (next_cal_tmr != '0);
            slow_pulse_a_n_out <= !((next_slow_tmr != '0) && next_slow_sel); // [R11]
            slow_pulse_b_n_out <= !((next_slow_tmr != '0) && !next_slow_sel); // [R11]
        end
    end

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic setup;
    logic [31:0] status_word;

    assign setup = psel_in && !penable_in;
    assign pready_out = psel_in && penable_in;
    assign status_word = {21'h0, fifo_level, freq_sel, gain_sel, hpf_on, supply_good}; // level sits in [10:6]

    // read data and error latched in the setup cycle
    always_comb
    begin
        next_prdata = prdata_out;
        next_pslverr = pslverr_out;
        if (setup)
        begin
            next_pslverr = 1'b0;
            case (paddr_in)
                APF_CTRL_OFS: next_prdata = {31'h0, soft_hold};
                APF_STATUS_OFS: next_prdata = status_word;
                APF_POWER_OFS: next_prdata = lpf_y[APF_PROD_W-1:APF_PROD_W-32];
                APF_CALCNT_OFS: next_prdata = cal_count;
                default:
                begin
                    next_prdata = 32'h0;
                    next_pslverr = 1'b1;
                end
            endcase
        end
    end

    // bus registers; control write lands in the access cycle
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            prdata_out <= 32'h0;
            pslverr_out <= 1'b0;
            soft_hold <= APF_CTRL_RST[0];
        end
        else
        begin
            prdata_out <= next_prdata;
            pslverr_out <= next_pslverr;
            if (pready_out && pwrite_in && paddr_in == APF_CTRL_OFS)
                soft_hold <= pwdata_in[0];
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (srst_in);

    sequence cal_fire_s;
        cal_evt && !rst_int;
    endsequence
    sequence cal_hold_s;
        cal_pulse_out [*2];
    endsequence

    gain_shift_a: assert property (pop && gain_sel == 2'h2 |-> gain_cur == 24'(fifo_data.cur) <<< 3) // [R1]
        else $error("gain eight not applied");
    supply_reset_a: assert property (!pin_sync.supply_ok |=> !supply_good ##1 !cal_pulse_out) // [R2]
        else $error("low supply did not reset");
    hpf_bypass_a: assert property (pop && !hpf_on && !rst_int |=> cur_q == $past(gain_cur)) // [R3] [R4]
        else $error("bypass passes filtered current");
    lpf_update_a: assert property (!stage_vld && !rst_int |=> $stable(lpf_y)) // [R5]
        else $error("low-pass moved without sample");
    cal_pulse_a: assert property (cal_fire_s |=> cal_hold_s) // [R7] [R8]
        else $error("calibration pulse missing");
    slow_ratio_a: assert property (slow_evt |-> cal_evt && ratio_cnt + 1'b1 >= ratio) // [R9]
        else $error("slow pulse without full ratio");
    slow_low_a: assert property (slow_evt && !rst_int |=> slow_pulse_a_n_out != slow_pulse_b_n_out) // [R11]
        else $error("slow pulse not driven low");
    reset_idle_a: assert property (rst_int |=> !cal_pulse_out && slow_pulse_a_n_out && slow_pulse_b_n_out) // [R13]
        else $error("outputs active in reset");
    ratio_sel_a: assert property (freq_sel == 2'h3 |-> ratio == 12'h100) // [R12]
        else $error("ratio wrong for top select");
endmodule

// [hdl/apf_pkg.sv]
// constants and types for the active power to frequency path
// How it works
// R1: pin pair picks current gain 1/2/8/16
// R2: low analog supply holds block in reset
// R3: filter pin high enables current high-pass
// R4: phase compensation only while high-pass enabled
// R5: multiply samples, low-pass the product
// R6: power low-pass corner near 8.9 hertz
// R7: integrate power into output pulse rate
// R8: calibration pulses up to 2048x slow rate
// R9: slow pulses from much longer accumulation
// R10: counter averages calibration pulses for power
// R11: slow pulse outputs are active low
// R12: freq pins pick slow scaling base
// R13: supply reset clears state, outputs idle
package apf_pkg;
    localparam int APF_SAMPLE_W = 16;
    localparam int APF_PROD_W = 40;
    // register byte offsets
    localparam logic [7:0] APF_CTRL_OFS = 8'h00;
    localparam logic [7:0] APF_STATUS_OFS = 8'h04;
    localparam logic [7:0] APF_POWER_OFS = 8'h08;
    localparam logic [7:0] APF_CALCNT_OFS = 8'h0c;
    localparam logic [31:0] APF_CTRL_RST = 32'h0000_0000;
    // filter shapes
    localparam real APF_LPF_CORNER_HZ = 8.9;
    localparam int APF_HPF_SHIFT = 10;
    localparam int APF_PC_SHIFT = 6;
    localparam int APF_LPF_SHIFT = 12;
    // slow to calibration ratio at lowest frequency select
    localparam int APF_MAX_RATIO_LOG2 = 11;
    // supply monitor filter and pulse widths in cycles
    localparam int APF_SUPPLY_FILT = 16;
    localparam int APF_PULSE_CYC = 64;
    localparam int APF_SAMPLE_GAP = 4;
    typedef struct packed {
        logic signed [APF_SAMPLE_W-1:0] cur;
        logic signed [APF_SAMPLE_W-1:0] volt;
    } apf_sample_t;
    typedef struct packed {
        logic gain_lsb;
        logic gain_msb;
        logic hpf_en;
        logic fsel_lsb;
        logic fsel_msb;
        logic supply_ok;
    } apf_pins_t;
endpackage

// [hdl/apf_fifo.sv]
// sample fifo with valid/ready on both sides
module apf_fifo
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
)
(
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in,
    output logic [$clog2(DEPTH):0] level_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic [AW:0] next_wr_ptr;
    logic [AW:0] next_rd_ptr;
    logic push;
    logic pop;

    // full and empty from pointer difference
    assign level_out = wr_ptr - rd_ptr;
    assign in_ready_out = (level_out != (AW+1)'(DEPTH));
    assign out_valid_out = (level_out != '0);
    assign out_data_out = mem[rd_ptr[AW-1:0]];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    // pointer next values
    always_comb
    begin
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    end

    // pointer and storage registers
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
        if (push)
            mem[wr_ptr[AW-1:0]] <= in_data_in;
    end

    fifo_bound_a: assert property (@(posedge clk_in) disable iff (srst_in)
        level_out <= (AW+1)'(DEPTH)) else $error("fifo level above depth");
endmodule

// [dv/apf_counter_model.sv]
// pulse counter model standing on the far side of the pulse outputs
module apf_counter_model
(
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic cal_pulse_in,
    input wire logic slow_a_n_in,
    input wire logic slow_b_n_in,
    input wire logic realign_in,
    output int cal_cnt_out,
    output int slow_cnt_out,
    output int order_err_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic cal_q;
    logic a_q;
    logic b_q;
    logic last_a;
    // ------------------------------------------------------------
    // edge counting, the reader averages counts over its own window
    // ------------------------------------------------------------
    always @(posedge clk_in)
    begin
        if (srst_in)
        begin
            cal_q <= 1'b0;
            a_q <= 1'b1;
            b_q <= 1'b1;
            last_a <= 1'b0;
            cal_cnt_out <= 0;
            slow_cnt_out <= 0;
            order_err_out <= 0;
        end
        else
        begin
            cal_q <= cal_pulse_in;
            a_q <= slow_a_n_in;
            b_q <= slow_b_n_in;
            // a held path restarts its alternation on side a
            if (realign_in)
                last_a <= 1'b0;
            if (cal_pulse_in && !cal_q)
                cal_cnt_out <= cal_cnt_out + 1;
            // falling edges mark the active-low pulses, same side twice is wrong
            if (a_q && !slow_a_n_in)
            begin
                slow_cnt_out <= slow_cnt_out + 1;
                order_err_out <= order_err_out + (last_a ? 1 : 0);
                last_a <= 1'b1;
            end
            if (b_q && !slow_b_n_in)
            begin
                slow_cnt_out <= slow_cnt_out + 1;
                order_err_out <= order_err_out + (last_a ? 0 : 1);
                last_a <= 1'b0;
            end
        end
    end
endmodule

// [dv/active_power_to_frequency_path_test.sv]
// self-checking bench for the active power to frequency path
module active_power_to_frequency_path_test;
    import apf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [31:0] ex; logic [31:0] m; logic er;} apf_note_t;
    apf_note_t q[$];
    apf_note_t nt;
    logic clk_in;
    logic srst_in;
    logic sup;
    logic [1:0] g;
    logic hpf;
    logic [1:0] fs;
    logic sv;
    apf_sample_t smp;
    logic sr;
    logic psel;
    logic pen;
    logic pwr;
    logic [7:0] pa;
    logic [31:0] pwd;
    logic [31:0] prd;
    logic prdy;
    logic perr;
    logic cal;
    logic fa_n;
    logic fb_n;
    logic realign;
    logic [31:0] last_rd;
    int cal_cnt;
    int slow_cnt;
    int ord_err;
    int err_count;
    int checks_done;
    int base;

    apf_core #(.CAL_THRESH_LOG2(30), .PULSE_CYC(4)) i_apf_core (.clk_in(clk_in), .srst_in(srst_in),
        .analog_supply_ok_in(sup), .gain_sel_lsb_in(g[0]), .gain_sel_msb_in(g[1]),
        .hpf_enable_pin_in(hpf), .freq_sel_lsb_in(fs[0]), .freq_sel_msb_in(fs[1]),
        .sample_valid_in(sv), .sample_in(smp), .sample_ready_out(sr), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd),
        .pready_out(prdy), .pslverr_out(perr), .cal_pulse_out(cal), .slow_pulse_a_n_out(fa_n),
        .slow_pulse_b_n_out(fb_n));
    apf_counter_model i_apf_counter_model (.clk_in(clk_in), .srst_in(srst_in), .cal_pulse_in(cal),
        .slow_a_n_in(fa_n), .slow_b_n_in(fb_n), .realign_in(realign), .cal_cnt_out(cal_cnt), .slow_cnt_out(slow_cnt),
        .order_err_out(ord_err));

    // ------------------------------------------------------------
    // clock, watchdog and shared tasks
    // ------------------------------------------------------------
    always #2.5 clk_in = ~clk_in;

    // cuts a hang short after twice the expected run length
    initial
    begin
        #400000;
        err_count++;
        final_report();
    end

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        checks_done++;
        if (got !== ex)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
        end
    endtask

    // one apb transfer, expected answer noted for the monitor
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       input logic [31:0] ex, input logic [31:0] m, input logic er);
        q.push_back('{ex, m, er});
        @(posedge clk_in);
        psel <= 1'b1;
        pwr <= wr;
        pa <= a;
        pwd <= wd;
        @(posedge clk_in);
        pen <= 1'b1;
        @(posedge clk_in);
        while (prdy !== 1'b1)
            @(posedge clk_in);
        last_rd = prd;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    // offers n samples, positive or negative current, random magnitudes
    task automatic push(input int n, input logic neg);
        for (int i = 0; i < n; i++)
        begin
            sv <= 1'b1;
            smp.cur <= {neg ? 3'b111 : 3'b001, 13'($urandom)};
            smp.volt <= {3'b001, 13'($urandom)};
            @(posedge clk_in);
            while (sr !== 1'b1)
                @(posedge clk_in);
        end
        sv <= 1'b0;
    endtask

    function automatic logic [31:0] st(input logic [1:0] f, input logic [1:0] gg, input logic h, input logic ok);
        return {26'h0, f, gg, h, ok};
    endfunction

    task automatic hold_pulse();
        realign <= 1'b1;
        apb(1'b1, APF_CTRL_OFS, 32'h1, 32'h0, 32'h0, 1'b0);
        apb(1'b1, APF_CTRL_OFS, 32'h0, 32'h0, 32'h0, 1'b0);
        realign <= 1'b0;
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // compares each finished apb transfer with the oldest note
    always @(posedge clk_in)
    begin
        if (psel === 1'b1 && pen === 1'b1 && prdy === 1'b1)
        begin
            nt = q.pop_front();
            chk("prdata", nt.ex & nt.m, prd & nt.m);
            chk("pslverr", {31'h0, nt.er}, {31'h0, perr});
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        {clk_in, sv, pwr, psel, pen, hpf, g, fs, realign} = '0;
        {srst_in, sup} = 2'b11;
        smp = '0;
        pa = 8'h00;
        pwd = 32'h0;
        void'($urandom(32'h33428193));
        repeat (2) @(posedge clk_in);
        srst_in <= 1'b0;
        @(posedge clk_in);
        chk("idle pulses", 32'h3, {29'h0, cal, fa_n, fb_n});
        repeat (30) @(posedge clk_in);
        apb(1'b0, APF_CTRL_OFS, 32'h0, APF_CTRL_RST, 32'hffffffff, 1'b0);
        for (int i = 0; i < 16; i++)
        begin
            g <= i[1:0];
            fs <= i[3:2];
            hpf <= i[0] ^ i[2];
            push(2, i[0]);
            repeat (4) @(posedge clk_in);
            apb(1'b0, APF_STATUS_OFS, 32'h0, st(i[3:2], i[1:0], i[0] ^ i[2], 1'b1), 32'h7ff, 1'b0);
        end
        apb(1'b1, APF_STATUS_OFS, 32'hffffffff, 32'h0, 32'h0, 1'b0);
        apb(1'b1, 8'h10, 32'hffffffff, 32'h0, 32'h0, 1'b1);
        apb(1'b0, 8'h10, 32'h0, 32'h0, 32'hffffffff, 1'b1);
        apb(1'b1, APF_CTRL_OFS, 32'h1, 32'h0, 32'h0, 1'b0);
        apb(1'b0, APF_CTRL_OFS, 32'h0, 32'h1, 32'hffffffff, 1'b0);
        apb(1'b1, APF_CTRL_OFS, 32'h0, 32'h0, 32'h0, 1'b0);
        // low supply: path held, no pulses
        {g, fs, hpf} <= 5'b11110;
        sup <= 1'b0;
        repeat (5) @(posedge clk_in);
        apb(1'b0, APF_STATUS_OFS, 32'h0, 32'h0, 32'h1, 1'b0);
        push(40, 1'b0);
        apb(1'b0, APF_CALCNT_OFS, 32'h0, 32'h0, 32'hffffffff, 1'b0);
        chk("cal edges", 32'h0, 32'(cal_cnt));
        sup <= 1'b1;
        repeat (30) @(posedge clk_in);
        // fill the fifo until it refuses, then let it drain
        push(60, 1'b0);
        @(negedge clk_in);
        chk("ready dropped", 32'h1, {31'h0, sr !== 1'b1});
        repeat (200) @(posedge clk_in);
        apb(1'b0, APF_STATUS_OFS, 32'h0, st(2'h3, 2'h3, 1'b0, 1'b1), 32'h7ff, 1'b0);
        // each frequency select: slow pulses per calibration event
        for (int f = 0; f < 4; f++)
        begin
            fs <= f[1:0];
            repeat (4) @(posedge clk_in);
            hold_pulse();
            base = slow_cnt;
            push(2200, 1'b0);
            repeat (300) @(posedge clk_in);
            apb(1'b0, APF_CALCNT_OFS, 32'h0, 32'h0, 32'h0, 1'b0);
            chk("cal events", 32'h1, {31'h0, last_rd != 32'h0});
            chk("slow pulses", last_rd >> (11 - f), 32'(slow_cnt - base));
            apb(1'b0, APF_POWER_OFS, 32'h0, 32'h0, 32'h0, 1'b0);
            chk("power positive", 32'h1, {31'h0, last_rd != 32'h0 && !last_rd[31]});
        end
        hold_pulse();
        push(500, 1'b1);
        repeat (300) @(posedge clk_in);
        apb(1'b0, APF_CALCNT_OFS, 32'h0, 32'h0, 32'hffffffff, 1'b0);
        chk("slow order", 32'h0, 32'(ord_err));
        final_report();
    end
endmodule
